// [ifs_regs.svh]
// Purpose: Offsets, field positions, reset values and timing counts of the fetch sequencer
// Assumes: APB byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef IFS_REGS_SVH
`define IFS_REGS_SVH

// ==========================================================
// Register offsets
`define IFS_OFF_PCL        12'h000
`define IFS_OFF_STATUS     12'h004
`define IFS_OFF_CTRL       12'h008

// ==========================================================
// Field positions
`define IFS_CTRL_RUN       0
`define IFS_CTRL_IEN       1
`define IFS_ST_FLAGS_LO    0
`define IFS_ST_PCHI_LO     8
`define IFS_ST_COUNT_LO    16
`define IFS_ST_FULL        20
`define IFS_ST_IRQ         21

// ==========================================================
// Reset values, vectors and page mask
`define IFS_CTRL_RESET     2'h1
`define IFS_RESET_VECTOR   12'h000
`define IFS_INT_VECTOR     12'h004
`define IFS_PAGE_MASK      12'hF00

// ==========================================================
// Sizes and timing
`define IFS_STACK_DEPTH    8
`define IFS_STACK_AW       3
`define IFS_PHASES         4

`endif

// [ifs_pkg.sv]
// Purpose: Types shared by the fetch sequencer files
// Assumes: No constants from ifs_regs.svh; the types stand alone
// Notes:   Nothing here is imported
package ifs_pkg;

    // ======================================================
    // Phases of one instruction cycle
    typedef enum logic [1:0] {
        IFS_T1 = 2'b00,
        IFS_T2 = 2'b01,
        IFS_T3 = 2'b10,
        IFS_T4 = 2'b11
    } ifs_phase_e;

    // ======================================================
    // Sequencing class of the executing instruction
    typedef enum logic [2:0] {
        IFS_K_SEQ    = 3'b000,
        IFS_K_ALU    = 3'b001,
        IFS_K_JUMP   = 3'b010,
        IFS_K_CALL   = 3'b011,
        IFS_K_RET    = 3'b100,
        IFS_K_INTERRUPT_RETURN   = 3'b101,
        IFS_K_SKIP   = 3'b110,
        IFS_K_PCLWR  = 3'b111
    } ifs_kind_e;

    typedef enum logic [3:0] {
        IFS_A_ADD  = 4'h0,
        IFS_A_ADC  = 4'h1,
        IFS_A_SUB  = 4'h2,
        IFS_A_SBC  = 4'h3,
        IFS_A_DAA  = 4'h4,
        IFS_A_AND  = 4'h5,
        IFS_A_OR   = 4'h6,
        IFS_A_XOR  = 4'h7,
        IFS_A_CPL  = 4'h8,
        IFS_A_RR   = 4'h9,
        IFS_A_RRC  = 4'hA,
        IFS_A_RL   = 4'hB,
        IFS_A_RLC  = 4'hC,
        IFS_A_INC  = 4'hD,
        IFS_A_DEC  = 4'hE,
        IFS_A_PASS = 4'hF
    } ifs_alu_op_e;

    // ======================================================
    // Decoded instruction from the external decoder
    typedef struct packed {
        ifs_kind_e   kind;
        ifs_alu_op_e aluOp;
        logic        skipOnNonZero;
        logic        writesFlags;
        logic [11:0] target;
    } ifs_decode_s;

    typedef struct packed {
        logic carry;
        logic auxCarry;
        logic zero;
        logic overflow;
    } ifs_flags_s;

    typedef struct packed {
        ifs_flags_s flags;
        logic [7:0] result;
    } ifs_alu_res_s;

endpackage : ifs_pkg

// [ifs_stack_mem.sv]
// Purpose: Return stack storage with registered read data
// Assumes: One write and one read address per cycle
// Notes:   Contents and read data are reset to zero, as is the pointer in the core
`timescale 1ns/100ps
`default_nettype none
`include "ifs_regs.svh"

module ifs_stack_mem #(
    parameter int DEPTH = `IFS_STACK_DEPTH,
    parameter int AW    = `IFS_STACK_AW
) (
    input  wire logic          clk,
    input  wire logic          reset_n,
    input  wire logic          writeEn,
    input  wire logic [AW-1:0] writeAddr,
    input  wire logic [11:0]   writeData,
    input  wire logic [AW-1:0] readAddr,
    output logic      [11:0]   readData
);

    typedef struct packed {
        logic [DEPTH-1:0][11:0] words;
        logic [11:0]            rdata;
    } ifs_mem_state_s;

    ifs_mem_state_s s_q;
    ifs_mem_state_s s_d;

    always_comb begin
        s_d = s_q;
        if (writeEn) begin
            s_d.words[writeAddr] = writeData;
        end
        s_d.rdata = s_q.words[readAddr];
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign readData = s_q.rdata;

endmodule // ifs_stack_mem

`default_nettype wire

// [ifs_core.sv]
// Purpose: Four-phase fetch/execute sequencer, program counter, return stack and ALU
// Assumes: External decoder turns execWord into decodedOp combinationally
// Notes:   Decisions are taken on the clock that ends phase four
//
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "ifs_regs.svh"

// Function
// - Four non-overlapping phases from the clock make one instruction cycle.
// - Counter advances at phase one end; fetch there; others decode and execute.
// - Next instruction fetched while current executes; sequential ones take one cycle.
// - Jumps, calls and other branches take two cycles; prefetched word flushed.
// - Taken conditional skip discards prefetched word and runs a dummy cycle.
// - Twelve-bit counter, four high bits, eight low; only low byte program-accessible.
// - Writing the low byte jumps within the page and inserts one dummy cycle.
// - Counter increments per instruction, loads target on jump, call, interrupt, reset.
// - Call or interrupt acknowledge pushes the counter; stack hidden from software.
// - Subroutine or interrupt return pops the stack into the counter.
// - Reset points the stack pointer at the empty top position.
// - Full stack: interrupt flag latched, acknowledge held until a return frees a level.
// - Call with full stack still executes, dropping the oldest saved address.
// - Eight-bit ALU writes result to destination and updates status flags when writesFlags is set.
// - ALU does add, subtract, decimal adjust, logic, rotates, inc, dec, zero skips.
// - Reset loads the counter with address zero and execution starts there.
module ifs_core #(
    parameter int DEPTH = `IFS_STACK_DEPTH
) (
    input  wire logic                clk,
    input  wire logic                reset_n,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Program memory
    output logic      [11:0]         pmAddr,
    input  wire logic [15:0]         pmData,
    // Decoder and data path
    output logic      [15:0]         execWord,
    output logic                     execValid,
    input  wire ifs_pkg::ifs_decode_s decodedOp,
    input  wire logic [7:0]          aluA,
    input  wire logic [7:0]          aluB,
    output logic      [7:0]          aluResult,
    output logic                     aluWrite,
    output ifs_pkg::ifs_flags_s      statusFlags,
    // Interrupt request and acknowledge, phase clocks
    input  wire logic                irqReq,
    output logic                     irqAck,
    output logic      [3:0]          instructionPhaseClocks
);

    localparam int AW = `IFS_STACK_AW;

    typedef struct packed {
        ifs_pkg::ifs_phase_e phase;
        logic [3:0]          phaseClk;
        logic [11:0]         pc;
        logic [11:0]         fetchAddr;
        logic [15:0]         execWord;
        logic                execValid;
        logic                pclPend;
        logic [7:0]          pclData;
        logic                irqFlag;
        logic                irqAck;
        logic [AW:0]         count;
        logic [AW-1:0]       top;
        logic [7:0]          aluRes;
        logic                aluWrite;
        ifs_pkg::ifs_flags_s flags;
        logic                run;
        logic                ien;
        logic [31:0]         prdata;
    } ifs_core_state_s;

    ifs_core_state_s s_q;
    ifs_core_state_s s_d;
    logic          pushEn;
    logic [AW-1:0] pushAddr;
    logic [11:0]   pushData;
    logic [11:0]   stackTop;

    // ======================================================
    // ALU
    function automatic ifs_pkg::ifs_alu_res_s aluCalc(input ifs_pkg::ifs_alu_op_e op,
                                                      input logic [7:0] a, input logic [7:0] b,
                                                      input logic cin);
        logic [8:0]            sum;
        logic [4:0]            half;
        logic [7:0]            bb;
        logic                  ci;
        logic                  arith;
        ifs_pkg::ifs_alu_res_s r;
        sum   = 9'h000;
        half  = 5'h00;
        bb    = b;
        ci    = 1'b0;
        arith = 1'b1;
        r     = '0;
        case (op)
            ifs_pkg::IFS_A_ADC: ci = cin;
            ifs_pkg::IFS_A_SUB: begin
                bb = ~b;
                ci = 1'b1;
            end
            ifs_pkg::IFS_A_SBC: begin
                bb = ~b;
                ci = cin;
            end
            ifs_pkg::IFS_A_INC: begin
                bb = 8'h01;
            end
            ifs_pkg::IFS_A_DEC: begin
                bb = 8'hFF;
            end
            default: arith = (op == ifs_pkg::IFS_A_ADD);
        endcase
        sum  = {1'b0, a} + {1'b0, bb} + {8'h00, ci};
        half = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, ci};
        r.flags.carry    = cin;
        r.flags.auxCarry = half[4];
        r.flags.overflow = (a[7] == bb[7]) && (sum[7] != a[7]);
        r.result         = sum[7:0];
        if (arith) begin
            r.flags.carry = sum[8];
        end
        case (op)
            ifs_pkg::IFS_A_DAA: begin
                sum = {1'b0, a};
                if ((a[3:0] > 4'h9) || cin) begin
                    sum = sum + 9'h006;
                end
                if ((sum[7:4] > 4'h9) || sum[8]) begin
                    sum = sum + 9'h060;
                end
                r.result      = sum[7:0];
                r.flags.carry = sum[8];
            end
            ifs_pkg::IFS_A_AND:  r.result = a & b;
            ifs_pkg::IFS_A_OR:   r.result = a | b;
            ifs_pkg::IFS_A_XOR:  r.result = a ^ b;
            ifs_pkg::IFS_A_CPL:  r.result = ~a;
            ifs_pkg::IFS_A_RR:   r.result = {a[0], a[7:1]};
            ifs_pkg::IFS_A_RL:   r.result = {a[6:0], a[7]};
            ifs_pkg::IFS_A_RRC: begin
                r.result      = {cin, a[7:1]};
                r.flags.carry = a[0];
            end
            ifs_pkg::IFS_A_RLC: begin
                r.result      = {a[6:0], cin};
                r.flags.carry = a[7];
            end
            ifs_pkg::IFS_A_PASS: r.result = a;
            default: ;
        endcase
        r.flags.zero = (r.result == 8'h00);
        return r;
    endfunction

    function automatic logic [3:0] phaseOneHot(input ifs_pkg::ifs_phase_e p);
        return 4'h1 << p;
    endfunction

    // ======================================================
    // Sequencer
    always_comb begin
        ifs_pkg::ifs_alu_res_s r;
        logic                  flush;
        logic                  pop;
        logic                  full;
        logic                  apbWr;
        r        = aluCalc(decodedOp.aluOp, aluA, aluB, s_q.flags.carry);
        flush    = 1'b0;
        pop      = 1'b0;
        pushEn   = 1'b0;
        pushData = s_q.pc - 12'h001;
        s_d      = s_q;
        full     = (s_q.count == (AW+1)'(DEPTH));
        apbWr    = psel && penable && pwrite;
        s_d.irqAck   = 1'b0;
        s_d.aluWrite = 1'b0;
        s_d.irqFlag  = (s_q.irqFlag && !s_q.irqAck) || irqReq;

        case (s_q.phase)
            ifs_pkg::IFS_T1: begin
                if (s_q.run) begin
                    s_d.fetchAddr = s_q.pc;
                    s_d.pc        = s_q.pc + 12'h001;
                    s_d.phase     = ifs_pkg::IFS_T2;
                end
            end
            ifs_pkg::IFS_T2: s_d.phase = ifs_pkg::IFS_T3;
            ifs_pkg::IFS_T3: s_d.phase = ifs_pkg::IFS_T4;
            ifs_pkg::IFS_T4: begin
                s_d.phase = ifs_pkg::IFS_T1;
                if (s_q.execValid) begin
                    if ((decodedOp.kind == ifs_pkg::IFS_K_ALU) || (decodedOp.kind == ifs_pkg::IFS_K_SKIP)) begin
                        s_d.aluRes   = r.result;
                        s_d.aluWrite = 1'b1;
                        if (decodedOp.writesFlags) begin
                            s_d.flags = r.flags;
                        end
                    end
                    case (decodedOp.kind)
                        ifs_pkg::IFS_K_JUMP: begin
                            s_d.pc = decodedOp.target;
                            flush  = 1'b1;
                        end
                        ifs_pkg::IFS_K_CALL: begin
                            pushEn = 1'b1;
                            s_d.pc = decodedOp.target;
                            flush  = 1'b1;
                        end
                        ifs_pkg::IFS_K_RET, ifs_pkg::IFS_K_INTERRUPT_RETURN: begin
                            pop    = 1'b1;
                            s_d.pc = stackTop;
                            flush  = 1'b1;
                        end
                        ifs_pkg::IFS_K_SKIP: begin
                            flush = decodedOp.skipOnNonZero ? !r.flags.zero : r.flags.zero;
                        end
                        ifs_pkg::IFS_K_PCLWR: begin
                            s_d.pc = {s_q.pc[11:8], r.result};
                            flush  = 1'b1;
                        end
                        default: ;
                    endcase
                end
                if (!flush && s_q.pclPend) begin
                    s_d.pc      = {s_q.pc[11:8], s_q.pclData};
                    s_d.pclPend = 1'b0;
                    flush       = 1'b1;
                end
                // acknowledge only with a free level
                if (!flush && s_q.irqFlag && s_q.ien && !full) begin
                    pushEn      = 1'b1;
                    s_d.pc      = `IFS_INT_VECTOR;
                    s_d.irqAck  = 1'b1;
                    s_d.irqFlag = irqReq;
                    flush       = 1'b1;
                end
                if (pushEn) begin
                    s_d.top = (s_q.top == AW'(DEPTH - 1)) ? '0 : s_q.top + 1'b1;
                    if (!full) begin
                        s_d.count = s_q.count + 1'b1;
                    end
                end else if (pop) begin
                    s_d.top = (s_q.top == '0) ? AW'(DEPTH - 1) : s_q.top - 1'b1;
                    if (s_q.count != '0) begin
                        s_d.count = s_q.count - 1'b1;
                    end
                end
                s_d.execWord  = pmData;
                s_d.execValid = !flush;
            end
            default: s_d.phase = ifs_pkg::IFS_T1;
        endcase
        s_d.phaseClk = s_q.run ? phaseOneHot(s_d.phase) : 4'h0;

        // ==================================================
        // APB access
        if (psel && !penable) begin
            case (paddr)
                `IFS_OFF_PCL:    s_d.prdata = {24'h00_0000, s_q.pc[7:0]};
                `IFS_OFF_STATUS: s_d.prdata = {10'h000, s_q.irqFlag, full,
                                               (4)'(s_q.count), 4'h0, s_q.pc[11:8], 4'h0, s_q.flags};
                `IFS_OFF_CTRL:   s_d.prdata = {30'h0000_0000, s_q.ien, s_q.run};
                default:         s_d.prdata = 32'h0000_0000;
            endcase
        end
        if (apbWr && (paddr == `IFS_OFF_PCL)) begin
            s_d.pclPend = 1'b1;
            s_d.pclData = pwdata[7:0];
        end
        if (apbWr && (paddr == `IFS_OFF_CTRL)) begin
            s_d.run = pwdata[`IFS_CTRL_RUN];
            s_d.ien = pwdata[`IFS_CTRL_IEN];
        end
        pushAddr = s_d.top;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q       <= '0;
            s_q.pc    <= `IFS_RESET_VECTOR;
            {s_q.ien, s_q.run} <= `IFS_CTRL_RESET;
            s_q.phase <= ifs_pkg::IFS_T1;
        end else begin
            s_q <= s_d;
        end
    end

    // ======================================================
    // Return stack storage
    ifs_stack_mem #(
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_stack (
        .clk       (clk),
        .reset_n   (reset_n),
        .writeEn   (pushEn),
        .writeAddr (pushAddr),
        .writeData (pushData),
        .readAddr  (s_q.top),
        .readData  (stackTop)
    );

    // ======================================================
    // Outputs
    assign pready                 = 1'b1;
    assign pslverr                = psel && penable && (paddr != `IFS_OFF_PCL) &&
                                    (paddr != `IFS_OFF_STATUS) && (paddr != `IFS_OFF_CTRL);
    assign prdata                 = s_q.prdata;
    assign pmAddr                 = s_q.fetchAddr;
    assign execWord               = s_q.execWord;
    assign execValid              = s_q.execValid;
    assign aluResult              = s_q.aluRes;
    assign aluWrite               = s_q.aluWrite;
    assign statusFlags            = s_q.flags;
    assign irqAck                 = s_q.irqAck;
    assign instructionPhaseClocks = s_q.phaseClk;

endmodule // ifs_core

`default_nettype wire

// [ifs_pm_model.sv]
// Purpose: Program memory and instruction decoder beside the fetch sequencer
// Assumes: Word is kind [15:13], skip sense [12], ALU op [11:8], target [11:0]
// Notes:   Only the low address byte selects a word; all else is a plain word
`timescale 1ns/100ps
`default_nettype none

module ifs_pm_model (
    input  wire logic [11:0]     pmAddr,
    output logic      [15:0]     pmData,
    input  wire logic [15:0]     execWord,
    output ifs_pkg::ifs_decode_s decodedOp
);
    logic [15:0] progMem [0:255];

    // ==========================================================
    // Test program
    initial begin
        for (int i = 0; i < 256; i++) progMem[i] = 16'h0000;
        progMem[8'h01] = 16'h2000;
        progMem[8'h02] = 16'h4010;
        progMem[8'h04] = 16'hA000;
        progMem[8'h10] = 16'h6020;
        progMem[8'h11] = 16'hC700;
        progMem[8'h14] = 16'h4013;
        progMem[8'h20] = 16'h8000;
        progMem[8'h31] = 16'h4031;
        progMem[8'h40] = 16'h6050;
        progMem[8'h50] = 16'h6060;
        progMem[8'h60] = 16'h6070;
        progMem[8'h70] = 16'h4070;
        progMem[8'h80] = 16'h8000;
    end

    assign pmData = progMem[pmAddr[7:0]];

    always_comb begin
        decodedOp.kind          = ifs_pkg::ifs_kind_e'(execWord[15:13]);
        decodedOp.aluOp         = ifs_pkg::ifs_alu_op_e'(execWord[11:8]);
        decodedOp.skipOnNonZero = execWord[12];
        decodedOp.writesFlags   = (execWord[15:13] == 3'b001);
        decodedOp.target        = execWord[11:0];
    end
endmodule // ifs_pm_model

`default_nettype wire

// [ifs_core_asserts.sv]
// Purpose: Port-level checker of the fetch sequencer
// Assumes: Bound into ifs_core
// Notes:   One clock domain
`include "ifs_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module ifs_core_asserts (
    input wire logic                 clk,
    input wire logic                 reset_n,
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic [11:0]          paddr,
    input wire logic                 pready,
    input wire logic                 pslverr,
    input wire logic [11:0]          pmAddr,
    input wire logic [15:0]          execWord,
    input wire logic                 execValid,
    input wire ifs_pkg::ifs_decode_s decodedOp,
    input wire logic                 aluWrite,
    input wire logic                 irqAck,
    input wire logic [3:0]           instructionPhaseClocks
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    // ==========================================================
    // Phases and pipeline
    a_phase_rotate: assert property (instructionPhaseClocks == 4'h2 |=>
        instructionPhaseClocks == 4'h4 ##1 instructionPhaseClocks == 4'h8)
        else $error("phase order broken");
    a_fetch_at_t1: assert property ($changed(pmAddr) |-> $past(instructionPhaseClocks) == 4'h1)
        else $error("fetch outside phase one");
    a_exec_at_t4: assert property ($changed({execWord, execValid}) |->
        $past(instructionPhaseClocks) == 4'h8)
        else $error("exec word outside phase four");
    a_jump_flush: assert property ((instructionPhaseClocks == 4'h8 && execValid &&
        decodedOp.kind == ifs_pkg::IFS_K_JUMP) |=> !execValid ##1 pmAddr == $past(decodedOp.target, 2))
        else $error("jump flush or target wrong");
    a_dummy_no_alu: assert property ((instructionPhaseClocks == 4'h8 && !execValid) |=> !aluWrite)
        else $error("dummy cycle wrote a result");
    a_alu_t4: assert property (aluWrite |-> $past(instructionPhaseClocks) == 4'h8 && !$past(aluWrite))
        else $error("result write out of phase");

    // ==========================================================
    // Interrupt acknowledge
    a_ack_pulse: assert property (irqAck |=> !irqAck)
        else $error("ack longer than a cycle");
    a_ack_vector: assert property (irqAck |-> ##[1:2] pmAddr == `IFS_INT_VECTOR)
        else $error("ack without vector fetch");

    // ==========================================================
    // Register bus
    a_pready_high: assert property (pready)
        else $error("ready low");
    a_slverr_map: assert property (pslverr == (psel && penable &&
        !(paddr inside {`IFS_OFF_PCL, `IFS_OFF_STATUS, `IFS_OFF_CTRL})))
        else $error("error response wrong");
endmodule // ifs_core_asserts

bind ifs_core ifs_core_asserts ifsCoreAssertsU (
    .clk, .reset_n, .psel, .penable, .paddr, .pready, .pslverr, .pmAddr, .execWord, .execValid, .decodedOp,
    .aluWrite, .irqAck, .instructionPhaseClocks
);

`default_nettype wire

// [instruction_fetch_sequencer_tb.sv]
// Purpose: Self-checking bench of the fetch sequencer
// Assumes: Program held by ifs_pm_model, stack depth two
// Notes:   Fetches are sampled in phase two
`include "ifs_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module instruction_fetch_sequencer_tb;
    localparam int DEPTH = 2;
    logic                 clk, reset_n, psel, penable, pwrite, pready, pslverr;
    logic                 execValid, aluWrite, irqReq, irqAck, err, seen, v;
    logic [11:0]          paddr, pmAddr;
    logic [31:0]          pwdata, prdata, rd;
    logic [15:0]          pmData, execWord;
    logic [7:0]           aluA, aluB, aluResult;
    logic [3:0]           instructionPhaseClocks;
    ifs_pkg::ifs_decode_s decodedOp;
    ifs_pkg::ifs_flags_s  statusFlags;
    int                   errorCnt, comparisons;

    ifs_core #(.DEPTH(DEPTH)) dut_u (.clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pmAddr, .pmData, .execWord, .execValid, .decodedOp, .aluA, .aluB, .aluResult,
        .aluWrite, .statusFlags, .irqReq, .irqAck, .instructionPhaseClocks);
    ifs_pm_model model_u (.pmAddr, .pmData, .execWord, .decodedOp);

    // ==========================================================
    // Shared tasks
    task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errorCnt++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] data);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic fetch(output logic [11:0] addr, output logic valid);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (instructionPhaseClocks !== 4'h2 && n < 16);
        addr = pmAddr;
        valid = execValid;
    endtask

    task automatic seek(input logic [11:0] target, output logic valid);
        logic [11:0] a;
        int          n;
        n = 0;
        do begin
            fetch(a, valid);
            n++;
        end while (a !== target && n < 40);
        check_val("fetch address", {20'h0, target}, {20'h0, a});
    endtask

    task automatic wait_ack(input int span, output logic seen);
        seen = 1'b0;
        for (int n = 0; n < span && !seen; n++) begin
            @(negedge clk);
            if (irqAck === 1'b1) seen = 1'b1;
        end
    endtask

    task automatic pulse_irq();
        @(posedge clk);
        irqReq <= 1'b1;
        @(posedge clk);
        irqReq <= 1'b0;
    endtask

    // ==========================================================
    // Scenarios
    task automatic test_pipeline();
        logic [11:0] expAddr [12] = '{12'h000, 12'h001, 12'h002, 12'h003, 12'h010, 12'h011,
                                      12'h020, 12'h021, 12'h011, 12'h012, 12'h013, 12'h014};
        logic [11:0] expValid = 12'b1010_1010_1110;
        logic [11:0] a;
        for (int i = 0; i < 12; i++) begin
            fetch(a, v);
            check_val("fetch address", {20'h0, expAddr[i]}, {20'h0, a});
            check_val("exec valid", {31'h0, expValid[i]}, {31'h0, v});
            if (i == 3) check_val("alu result", 32'h24, {24'h0, aluResult});
            if (i == 3) check_val("flags", 32'h0, {28'h0, statusFlags});
        end
        $display("test_pipeline done");
    endtask

    task automatic test_regs();
        apb(1'b0, `IFS_OFF_STATUS, 32'h0);
        check_val("stack state", 32'h0, {26'h0, rd[21:16]});
        apb(1'b0, `IFS_OFF_CTRL, 32'h0);
        check_val("control", 32'h1, rd);
        apb(1'b0, 12'h00C, 32'h0);
        check_val("unmapped error", 32'h1, {31'h0, err});
        check_val("unmapped data", 32'h0, rd);
        $display("test_regs done");
    endtask

    task automatic test_pcl();
        apb(1'b1, `IFS_OFF_PCL, 32'h30);
        seek(12'h030, v);
        check_val("dummy after page jump", 32'h0, {31'h0, v});
        apb(1'b0, `IFS_OFF_STATUS, 32'h0);
        check_val("pc high", 32'h0, {28'h0, rd[11:8]});
        $display("test_pcl done");
    endtask

    task automatic test_irq();
        apb(1'b1, `IFS_OFF_CTRL, 32'h3);
        pulse_irq();
        wait_ack(200, seen);
        check_val("irq ack", 32'h1, {31'h0, seen});
        seek(`IFS_INT_VECTOR, v);
        seek(12'h031, v);
        $display("test_irq done");
    endtask

    task automatic test_full();
        apb(1'b1, `IFS_OFF_PCL, 32'h40);
        seek(12'h070, v);
        apb(1'b0, `IFS_OFF_STATUS, 32'h0);
        check_val("stack count", DEPTH, {28'h0, rd[19:16]});
        check_val("stack full", 32'h1, {31'h0, rd[20]});
        pulse_irq();
        wait_ack(100, seen);
        check_val("ack held", 32'h0, {31'h0, seen});
        apb(1'b0, `IFS_OFF_STATUS, 32'h0);
        check_val("irq latched", 32'h1, {31'h0, rd[21]});
        apb(1'b1, `IFS_OFF_PCL, 32'h80);
        wait_ack(100, seen);
        check_val("ack after return", 32'h1, {31'h0, seen});
        $display("test_full done");
    endtask

    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", comparisons, errorCnt);
        if (errorCnt == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // Clock, reset, sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial begin
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        aluA = 8'h12;
        aluB = 8'h12;
        irqReq = 1'b0;
        errorCnt = 0;
        comparisons = 0;
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        test_pipeline();
        test_regs();
        test_pcl();
        test_irq();
        test_full();
        finish_test();
    end

    initial begin
        #200000;
        errorCnt++;
        finish_test();
    end
endmodule // instruction_fetch_sequencer_tb

`default_nettype wire
